// ### common/ccw_pkg.sv
package ccw_pkg;

  // Legacy socket index of each register; the memory map places them at base + 800h + index
  localparam logic [7:0] IDX_GATE = 8'h06;
  localparam logic [7:0] IDX_IO_CTRL = 8'h07;
  localparam logic [7:0] IDX_IO0_START_LO = 8'h08;
  localparam logic [7:0] IDX_IO0_START_HI = 8'h09;
  localparam logic [7:0] IDX_IO0_END_LO = 8'h0A;
  localparam logic [7:0] IDX_IO0_END_HI = 8'h0B;
  localparam logic [7:0] IDX_IO1_START_LO = 8'h0C;
  localparam logic [7:0] IDX_IO1_START_HI = 8'h0D;
  localparam logic [7:0] IDX_IO1_END_LO = 8'h0E;
  localparam logic [7:0] IDX_IO1_END_HI = 8'h0F;
  localparam logic [7:0] IDX_IO_STRIDE = 8'h04;
  localparam logic [7:0] IDX_LIMIT = 8'h10;
  localparam logic [3:0] MEM_PAGE = 4'h8;

  // Field layout of the window gate register
  localparam int GATE_IO1_BIT = 7;
  localparam int GATE_IO0_BIT = 6;
  localparam int GATE_RSVD_BIT = 5;
  localparam int GATE_MEM_LSB = 0;
  localparam int MEM_WINDOWS = 5;
  localparam logic [7:0] GATE_WRITE_MASK = 8'hDF;
  localparam logic [7:0] GATE_RESET = 8'h00;

  // Field layout of the I/O width and timing register, one nibble per window
  localparam int IO_WINDOWS = 2;
  localparam int IOCTL_NIBBLE = 4;
  localparam int IOCTL_FIXED_WIDTH = 0;
  localparam int IOCTL_FROM_CARD = 1;
  localparam int IOCTL_SHORT_CYCLE = 2;
  localparam int IOCTL_EXTRA_WAIT = 3;
  localparam logic [7:0] IOCTL_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;

  // Register access from the host, either by memory offset or by legacy index
  typedef struct packed {
    logic valid;
    logic write;
    logic byMemory;
    logic [11:0] addr;
    logic [7:0] wdata;
  } ccw_reg_req_t;

  typedef struct packed {
    logic ack;
    logic mapped;
    logic [7:0] rdata;
  } ccw_reg_rsp_t;

  // Host cycle aimed at the card; memory window address compares arrive as hits
  typedef struct packed {
    logic valid;
    logic isIo;
    logic isMem;
    logic [15:0] ioAddr;
    logic [MEM_WINDOWS-1:0] memInRange;
  } ccw_cycle_t;

  typedef struct packed {
    logic claim;
    logic [IO_WINDOWS-1:0] ioWindow;
    logic [MEM_WINDOWS-1:0] memWindow;
    logic width16;
    logic extraWait;
    logic shortCycle;
  } ccw_claim_t;

endpackage

// ### logic/ccw_window_gate.sv
`timescale 1ns/100ps

// Behaviour
// - Never claim a cycle to a window whose enable bit is clear.
// - Window enable register resets to zero; all windows start disabled.
// - Enable bit 7 gates I/O window one.
// - Enable bit 6 gates I/O window zero.
// - Enable bit 5 reads zero; writes to it do nothing.
// - Enable bits 4..0 gate memory windows 4..0.
// - Control bit 7 adds one wait state to 16-bit window one accesses.
// - Control bit 6 shortens 8-bit window one accesses to three ISA cycles.
// - Control bit 5 makes the card's width signal decide window one width.
// - Control bit 4 fixes window one width, ignored while bit 5 set.
// - Control bit 3 adds one wait state to 16-bit window zero accesses.
// - Control bit 2 shortens 8-bit window zero accesses to three ISA cycles.
// - Control bit 1 makes the card's width signal decide window zero width.
// - Control bit 0 fixes window zero width, ignored while bit 1 set.
// - Registers reachable at base plus 806h/807h and at index 06h/07h.
// - Each I/O window has 16-bit start and end, split into byte registers.
module ccw_window_gate (
  input wire logic clock,
  input wire logic reset,
  // Register access
  input ccw_pkg::ccw_reg_req_t regReq,
  output ccw_pkg::ccw_reg_rsp_t regRsp,
  // Card cycle decode
  input ccw_pkg::ccw_cycle_t cycleReq,
  input wire logic cardIois16,
  output ccw_pkg::ccw_claim_t cycleClaim,
  // Window enables as seen by the cycle generator
  output logic [7:0] gateState
);
  import ccw_pkg::*;

  // Folds both access paths onto one legacy index; bit 8 flags a mapped register
  function automatic logic [8:0] decodeIndex(input ccw_reg_req_t r);
    logic [7:0] idx;
    logic hit;
    idx = 8'h00;
    hit = 1'b0;
    if (r.byMemory) begin
      idx = {4'h0, r.addr[3:0]};
      hit = (r.addr[11:8] == MEM_PAGE) && (r.addr[7:4] == 4'h0);
    end else begin
      idx = r.addr[7:0];
      hit = (r.addr[11:8] == 4'h0);
    end
    hit = hit && (idx >= IDX_GATE) && (idx < IDX_LIMIT);
    return {hit, idx};
  endfunction

  // Write strobe of one register index, shared by every writable register
  function automatic logic writeStrobe(input logic hitNow, input logic [7:0] idxNow,
    input logic [7:0] target);
    return hitNow && (idxNow == target);
  endfunction

  // Both bounds are inclusive
  function automatic logic inWindow(input logic [15:0] a, input logic [15:0] lo,
    input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  logic [7:0] gate_reg;
  logic [7:0] ioCtrl_reg;
  logic [7:0] startLo_reg [IO_WINDOWS];
  logic [7:0] startHi_reg [IO_WINDOWS];
  logic [7:0] endLo_reg [IO_WINDOWS];
  logic [7:0] endHi_reg [IO_WINDOWS];
  logic rspAck_reg;
  logic rspMapped_reg;
  logic [7:0] rspData_reg;
  ccw_claim_t claim_reg;
  ccw_claim_t claim_next;
  logic [8:0] dec;
  logic [7:0] readMux;
  logic writeHit;
  logic [IO_WINDOWS-1:0] ioHit;
  logic [IO_WINDOWS-1:0] ioWide;
  logic [IO_WINDOWS-1:0] ioWait;
  logic [IO_WINDOWS-1:0] ioShort;

  assign dec = decodeIndex(regReq);
  assign writeHit = regReq.valid && regReq.write && dec[8];

  // Named fields of the window gate register
  logic ioWindowOneGate;
  logic ioWindowZeroGate;
  logic memoryWindowFourGate;
  logic memoryWindowThreeGate;
  logic memoryWindowTwoGate;
  logic memoryWindowOneGate;
  logic memoryWindowZeroGate;
  logic [IO_WINDOWS-1:0] ioGate;
  logic [MEM_WINDOWS-1:0] memGate;

  assign ioWindowOneGate = gate_reg[GATE_IO1_BIT];
  assign ioWindowZeroGate = gate_reg[GATE_IO0_BIT];
  assign memoryWindowFourGate = gate_reg[GATE_MEM_LSB + 4];
  assign memoryWindowThreeGate = gate_reg[GATE_MEM_LSB + 3];
  assign memoryWindowTwoGate = gate_reg[GATE_MEM_LSB + 2];
  assign memoryWindowOneGate = gate_reg[GATE_MEM_LSB + 1];
  assign memoryWindowZeroGate = gate_reg[GATE_MEM_LSB];
  assign ioGate = {ioWindowOneGate, ioWindowZeroGate};
  assign memGate = {memoryWindowFourGate, memoryWindowThreeGate, memoryWindowTwoGate,
    memoryWindowOneGate, memoryWindowZeroGate};

  // Named fields of the I/O width and timing register
  logic ioOneExtraWait;
  logic ioOneShortCycle;
  logic ioOneWidthFromCard;
  logic ioOneFixedWidth;
  logic ioZeroExtraWait;
  logic ioZeroShortCycle;
  logic ioZeroWidthFromCard;
  logic ioZeroFixedWidth;
  logic [IO_WINDOWS-1:0] extraWaitSel;
  logic [IO_WINDOWS-1:0] shortCycleSel;
  logic [IO_WINDOWS-1:0] fromCardSel;
  logic [IO_WINDOWS-1:0] fixedWidthSel;

  assign ioOneExtraWait = ioCtrl_reg[IOCTL_NIBBLE + IOCTL_EXTRA_WAIT];
  assign ioOneShortCycle = ioCtrl_reg[IOCTL_NIBBLE + IOCTL_SHORT_CYCLE];
  assign ioOneWidthFromCard = ioCtrl_reg[IOCTL_NIBBLE + IOCTL_FROM_CARD];
  assign ioOneFixedWidth = ioCtrl_reg[IOCTL_NIBBLE + IOCTL_FIXED_WIDTH];
  assign ioZeroExtraWait = ioCtrl_reg[IOCTL_EXTRA_WAIT];
  assign ioZeroShortCycle = ioCtrl_reg[IOCTL_SHORT_CYCLE];
  assign ioZeroWidthFromCard = ioCtrl_reg[IOCTL_FROM_CARD];
  assign ioZeroFixedWidth = ioCtrl_reg[IOCTL_FIXED_WIDTH];
  assign extraWaitSel = {ioOneExtraWait, ioZeroExtraWait};
  assign shortCycleSel = {ioOneShortCycle, ioZeroShortCycle};
  assign fromCardSel = {ioOneWidthFromCard, ioZeroWidthFromCard};
  assign fixedWidthSel = {ioOneFixedWidth, ioZeroFixedWidth};

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gate_reg <= GATE_RESET;
    end else if (writeStrobe(writeHit, dec[7:0], IDX_GATE)) begin
      // Reserved bit stays zero whatever is written
      gate_reg <= regReq.wdata & GATE_WRITE_MASK;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ioCtrl_reg <= IOCTL_RESET;
    end else if (writeStrobe(writeHit, dec[7:0], IDX_IO_CTRL)) begin
      ioCtrl_reg <= regReq.wdata;
    end
  end

  // Address byte registers and per-window decode
  genvar w;
  generate
    for (w = 0; w < IO_WINDOWS; w++) begin : gIoWin
      localparam logic [7:0] BASE = IDX_IO0_START_LO + 8'(IDX_IO_STRIDE * w);
      logic [15:0] startAddr;
      logic [15:0] endAddr;
      logic wide;

      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          startLo_reg[w] <= ADDR_RESET;
        end else if (writeStrobe(writeHit, dec[7:0], BASE)) begin
          startLo_reg[w] <= regReq.wdata;
        end
      end

      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          startHi_reg[w] <= ADDR_RESET;
        end else if (writeStrobe(writeHit, dec[7:0], BASE + 8'h01)) begin
          startHi_reg[w] <= regReq.wdata;
        end
      end

      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          endLo_reg[w] <= ADDR_RESET;
        end else if (writeStrobe(writeHit, dec[7:0], BASE + 8'h02)) begin
          endLo_reg[w] <= regReq.wdata;
        end
      end

      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          endHi_reg[w] <= ADDR_RESET;
        end else if (writeStrobe(writeHit, dec[7:0], BASE + 8'h03)) begin
          endHi_reg[w] <= regReq.wdata;
        end
      end

      assign startAddr = {startHi_reg[w], startLo_reg[w]};
      assign endAddr = {endHi_reg[w], endLo_reg[w]};
      // Fixed width bit only matters while the card is not sizing the transfer
      assign wide = fromCardSel[w] ? cardIois16 : fixedWidthSel[w];
      assign ioWide[w] = wide;
      assign ioWait[w] = wide && extraWaitSel[w];
      assign ioShort[w] = !wide && shortCycleSel[w];
      assign ioHit[w] = ioGate[w]
        && inWindow(cycleReq.ioAddr, startAddr, endAddr);
    end
  endgenerate

  logic [IO_WINDOWS-1:0] ioPick;
  logic pickWide;
  logic pickWait;
  logic pickShort;

  // Window one wins if both overlap, matching a fixed priority a cycle generator can rely on
  always_comb begin
    ioPick = 2'b00;
    pickWide = 1'b0;
    pickWait = 1'b0;
    pickShort = 1'b0;
    if (ioHit[1]) begin
      ioPick = 2'b10;
      pickWide = ioWide[1];
      pickWait = ioWait[1];
      pickShort = ioShort[1];
    end else if (ioHit[0]) begin
      ioPick = 2'b01;
      pickWide = ioWide[0];
      pickWait = ioWait[0];
      pickShort = ioShort[0];
    end
  end

  always_comb begin
    claim_next = '0;
    if (cycleReq.valid && cycleReq.isIo) begin
      claim_next.claim = |ioHit;
      claim_next.ioWindow = ioPick;
      claim_next.width16 = pickWide;
      claim_next.extraWait = pickWait;
      claim_next.shortCycle = pickShort;
    end else if (cycleReq.valid && cycleReq.isMem) begin
      claim_next.memWindow = cycleReq.memInRange & memGate;
      claim_next.claim = |claim_next.memWindow;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      claim_reg <= '0;
    end else begin
      claim_reg <= claim_next;
    end
  end

  always_comb begin
    readMux = 8'h00;
    if (dec[8]) begin
      unique case (dec[7:0])
        IDX_GATE: readMux = gate_reg;
        IDX_IO_CTRL: readMux = ioCtrl_reg;
        IDX_IO0_START_LO: readMux = startLo_reg[0];
        IDX_IO0_START_HI: readMux = startHi_reg[0];
        IDX_IO0_END_LO: readMux = endLo_reg[0];
        IDX_IO0_END_HI: readMux = endHi_reg[0];
        IDX_IO1_START_LO: readMux = startLo_reg[1];
        IDX_IO1_START_HI: readMux = startHi_reg[1];
        IDX_IO1_END_LO: readMux = endLo_reg[1];
        IDX_IO1_END_HI: readMux = endHi_reg[1];
        default: readMux = 8'h00;
      endcase
    end
  end

  // Every request is acknowledged next cycle; unmapped ones read zero and write nothing
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rspAck_reg <= 1'b0;
    end else begin
      rspAck_reg <= regReq.valid;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rspMapped_reg <= 1'b0;
    end else begin
      rspMapped_reg <= regReq.valid && dec[8];
    end
  end

  // Writes return zero so a stale read value never rides on a write acknowledge
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rspData_reg <= 8'h00;
    end else begin
      rspData_reg <= (regReq.valid && !regReq.write) ? readMux : 8'h00;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gateState <= GATE_RESET;
    end else begin
      gateState <= gate_reg;
    end
  end

  assign regRsp = '{rspAck_reg, rspMapped_reg, rspData_reg};
  assign cycleClaim = claim_reg;

endmodule // ccw_window_gate

// ### tb/ccw_window_gate_assertions.sv
`timescale 1ns/100ps
module ccw_window_gate_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register bus
  input ccw_pkg::ccw_reg_req_t regReq,
  input ccw_pkg::ccw_reg_rsp_t regRsp,
  // Card side
  input ccw_pkg::ccw_cycle_t cycleReq,
  input wire logic cardIois16,
  input ccw_pkg::ccw_claim_t cycleClaim,
  input wire logic [7:0] gateState
);
  import ccw_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  ack_timing_a:
    assert property (regReq.valid |=> regRsp.ack) else $error("ack missing");
  ack_cause_a:
    assert property (regRsp.ack |-> $past(regReq.valid)) else $error("stray ack");
  unmapped_zero_a:
    assert property (regRsp.ack && !regRsp.mapped |-> regRsp.rdata == 8'h00)
      else $error("unmapped data");
  gate_mirror_a:
    assert property ($past(regReq.valid && !regReq.write && (regReq.addr == (regReq.byMemory
      ? {MEM_PAGE, IDX_GATE} : {4'h0, IDX_GATE}))) |-> regRsp.rdata == gateState)
      else $error("gate readback");
  reserved_zero_a:
    assert property (gateState[5] == 1'b0) else $error("reserved bit set");
  reset_clear_a:
    assert property ($fell(reset) |-> gateState == 8'h00) else $error("gate not cleared");
  io_zero_gate_a:
    assert property (cycleClaim.ioWindow[0] |-> gateState[6]) else $error("io0 gated");
  io_one_gate_a:
    assert property (cycleClaim.ioWindow[1] |-> gateState[7]) else $error("io1 gated");
  mem_gate_a:
    assert property ((cycleClaim.memWindow & ~gateState[4:0]) == 5'h00)
      else $error("mem gated");
  claim_window_a:
    assert property (cycleClaim.claim |-> |{cycleClaim.ioWindow, cycleClaim.memWindow})
      else $error("claim without window");
  claim_cause_a:
    assert property (cycleClaim.claim |-> $past(cycleReq.valid)) else $error("stray claim");
  wait_wide_a:
    assert property (cycleClaim.extraWait |-> cycleClaim.width16) else $error("wait on 8-bit");
  short_narrow_a:
    assert property (cycleClaim.shortCycle |-> !cycleClaim.width16) else $error("short on 16");
  cover property (cycleClaim.claim && cycleClaim.width16);
  cover property (cycleClaim.shortCycle);
  cover property (regRsp.ack && !regRsp.mapped);
endmodule // ccw_window_gate_assertions

bind ccw_window_gate ccw_window_gate_assertions u_chk (.clock(clock), .reset(reset),
  .regReq(regReq), .regRsp(regRsp), .cycleReq(cycleReq), .cardIois16(cardIois16),
  .cycleClaim(cycleClaim), .gateState(gateState));

// ### tb/ccw_card_model.sv
`timescale 1ns/100ps
module ccw_card_model (
  // Cycle seen at the socket
  input ccw_pkg::ccw_cycle_t cycleReq,
  // Width answer
  output logic cardIois16
);
  import ccw_pkg::*;
  // Ports with address bit 4 clear are 16-bit; silent outside I/O cycles
  assign cardIois16 = cycleReq.valid & cycleReq.isIo & ~cycleReq.ioAddr[4];
endmodule // ccw_card_model

// ### tb/test_ccw_window_gate.sv
`timescale 1ns/100ps
module test_ccw_window_gate;
  import ccw_pkg::*;
  logic clock, reset, cardIois16, cycPend;
  ccw_reg_req_t regReq;
  ccw_reg_rsp_t regRsp;
  ccw_cycle_t cycleReq;
  ccw_claim_t cycleClaim, expC;
  logic [7:0] gateState, g, c;
  logic [4:0] m;
  logic [8:0] regQ[$];
  ccw_claim_t cycQ[$];
  logic [7:0] wv [8] = '{8'h00, 8'h01, 8'hFF, 8'h01, 8'h00, 8'h03, 8'hFF, 8'h03};
  logic [15:0] ta [6] = '{16'h0100, 16'h01FF, 16'h0110, 16'h0300, 16'h03F0, 16'h0200};
  int miscompares, samples_checked, cycles;
  integer seed;

  ccw_window_gate u_dut (.clock(clock), .reset(reset), .regReq(regReq), .regRsp(regRsp),
    .cycleReq(cycleReq), .cardIois16(cardIois16), .cycleClaim(cycleClaim),
    .gateState(gateState));
  ccw_card_model u_card (.cycleReq(cycleReq), .cardIois16(cardIois16));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(string name, logic [10:0] got, logic [10:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Requests may follow every cycle; each task drops the other request kind
  task automatic acc(logic wr, logic mem, logic [7:0] idx, logic [7:0] d, logic [8:0] exp);
    @(negedge clock);
    cycleReq.valid = 1'b0;
    regReq = '{1'b1, wr, mem, {mem ? MEM_PAGE : 4'h0, idx}, d};
    regQ.push_back(exp);
  endtask

  task automatic cyc(logic io, logic [15:0] a, logic [4:0] mi, ccw_claim_t e);
    @(negedge clock);
    regReq.valid = 1'b0;
    cycleReq = '{1'b1, io, !io, a, mi};
    cycQ.push_back(e);
  endtask

  function automatic ccw_claim_t expIo(logic [15:0] a);
    logic w0, w1, w16;
    logic [3:0] n;
    w0 = g[6] && a >= 16'h0100 && a <= 16'h01FF;
    w1 = g[7] && a >= 16'h0300 && a <= 16'h03FF;
    n = w1 ? c[7:4] : c[3:0];
    w16 = n[1] ? !a[4] : n[0];
    if (!(w0 || w1))
      return '0;
    return '{1'b1, {w1, w0}, 5'h00, w16, w16 & n[3], !w16 & n[2]};
  endfunction

  always @(posedge clock) cycPend <= !reset && cycleReq.valid;

  always @(negedge clock) begin
    if (regRsp.ack === 1'b1)
      check("reg", {2'b00, regRsp.mapped, regRsp.rdata}, {2'b00, regQ.pop_front()});
    if (cycPend) begin
      expC = cycQ.pop_front();
      check("claim", cycleClaim, expC);
    end
  end

  // Ceiling is several times the planned run
  always @(posedge clock) begin
    cycles++;
    if (cycles > 3000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    seed = 32'heedf1f11;
    {miscompares, samples_checked, cycles} = '0;
    {regReq, cycleReq, g, c} = '0;
    reset = 1'b1;
    repeat (8) @(posedge clock);
    @(negedge clock) reset = 1'b0;
    acc(0, 1, IDX_GATE, 8'h00, 9'h100);
    acc(0, 0, IDX_IO_CTRL, 8'h00, 9'h100);
    acc(1, 0, 8'h20, 8'h5A, 9'h000);
    acc(0, 1, 8'h20, 8'h00, 9'h000);
    $display("reset and map test done");
    for (int i = 0; i < 8; i++) acc(1, i[0], IDX_IO0_START_LO + 8'(i), wv[i], 9'h100);
    for (int i = 0; i < 8; i++)
      acc(0, !i[0], IDX_IO0_START_LO + 8'(i), 8'h00, {1'b1, wv[i]});
    acc(1, 0, IDX_GATE, 8'hFF, 9'h100);
    acc(0, 1, IDX_GATE, 8'h00, 9'h1DF);
    g = 8'hDF;
    $display("gate test done");
    for (int k = 0; k < 16; k++) begin
      c = {k[3:0], ~k[3:0]};
      acc(1, k[0], IDX_IO_CTRL, c, 9'h100);
      acc(0, !k[0], IDX_IO_CTRL, 8'h00, {1'b1, c});
      foreach (ta[i]) cyc(1, ta[i], 5'h00, expIo(ta[i]));
    end
    $display("io window test done");
    for (int k = 0; k < 24; k++) begin
      g = $random(seed);
      m = $random(seed);
      acc(1, k[0], IDX_GATE, g, 9'h100);
      g[5] = 1'b0;
      cyc(0, 16'h0000, m, '{|(g[4:0] & m), 2'b00, g[4:0] & m, 1'b0, 1'b0, 1'b0});
      cyc(1, 16'h0300, 5'h00, expIo(16'h0300));
    end
    $display("memory window test done");
    @(negedge clock);
    {regReq.valid, cycleReq.valid} = 2'b00;
    repeat (3) @(negedge clock);
    close_out();
  end
endmodule // test_ccw_window_gate
